// ### fault_ctrl.sv
/*
 Fault-response sequencer of an overcurrent protection switch, with APB registers.
 Assumes condition inputs from comparators, a three-level strap seen as two bits,
 and a power-on reset on sys_rst_i.
*/
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "fault_params.svh"
module fault_ctrl
  import fault_pkg::*;
#(
  parameter int unsigned DEF_START_CYC = `DEF_START_CYC,
  parameter int unsigned RETRY_CYC     = `RETRY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  input  wire logic [1:0]  limit_mode_strap_i,
  input  wire logic        overcurrent_i,
  input  wire logic        output_good_i,
  input  wire logic        thermal_trip_i,
  input  wire logic        enable_i,
  input  wire logic        startup_timing_input_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             output_switch_o,
  output logic             regulate_o,
  output logic             forward_fault_n_o,
  output logic             forward_fault_oe_o
);
  // Elaboration check: a zero interval would never expire
  if (DEF_START_CYC < 1 || RETRY_CYC < 1) begin : g_bad_interval
    $error("fault_ctrl: interval counts must be at least one cycle");
  end
  localparam logic [31:0] OPEN_CYC = 32'(`OPEN_DETECT_CYC);
  localparam logic [31:0] DEF_CYC  = 32'(DEF_START_CYC);
  localparam logic [31:0] RTY_CYC  = 32'(RETRY_CYC);
  // ****************************************
  // Input synchronisation
  // ****************************************
  cond_if #(.W(`IN_WIDTH)) cin ();
  assign cin.raw = {startup_timing_input_i, enable_i, thermal_trip_i,
                    output_good_i, overcurrent_i, limit_mode_strap_i};
  cond_sync #(.W(`IN_WIDTH)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .c         (cin.sampler)
  );
  wire logic [1:0] strap_s  = cin.sync[`IN_STRAP_LSB +: 2];
  wire logic       oc_s     = cin.sync[`IN_OC_BIT];
  wire logic       good_s   = cin.sync[`IN_GOOD_BIT];
  wire logic       therm_s  = cin.sync[`IN_THERM_BIT];
  wire logic       en_s     = cin.sync[`IN_EN_BIT];
  wire logic       timing_s = cin.sync[`IN_TIMING_BIT];
  // ****************************************
  // Strap capture
  // ****************************************
  // Strap is read once, after the synchroniser has filled
  limit_mode_t mode;
  logic [1:0]  strap_wait;
  wire logic   mode_ok = (strap_wait == 2'h3);
  wire limit_mode_t strap_mode = (strap_s == 2'h0) ? MODE_CONT :
                                 (strap_s == 2'h1) ? MODE_LATCH : MODE_AUTO;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_wait <= 2'h0;
      mode       <= MODE_CONT;
    end else if (ce_i && !mode_ok) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        mode <= strap_mode;
      end
    end
  end
  // ****************************************
  // Registers and state
  // ****************************************
  seq_state_t  state;
  seq_state_t  next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] blank_cnt;
  logic [31:0] next_blank;
  logic        fault;
  logic        next_fault;
  logic        open_det;
  logic        next_open;
  logic [31:0] start_reg;
  logic [31:0] blank_reg;
  // A zero interval register wraps to a huge count; software writes at least one
  wire logic [31:0] start_lim = open_det ? DEF_CYC : start_reg;
  wire logic start_exp = (cnt >= start_lim - 32'h1);
  wire logic blank_hit = oc_s && (blank_cnt >= blank_reg - 32'h1);
  wire logic retry_exp = (cnt >= RTY_CYC - 32'h1);
  wire seq_state_t fail_state = (mode == MODE_AUTO) ? ST_RETRY : ST_LATCH;
  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_blank = blank_cnt;
    next_fault = fault;
    next_open  = open_det;
    if (!en_s) begin
      next_state = ST_OFF;
      next_cnt   = 32'h0;
      next_blank = 32'h0;
      next_fault = 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_START;
          next_cnt   = 32'h0;
          next_open  = 1'b0;
        end
        ST_START: begin
          next_cnt = cnt + 32'h1;
          // Only an early crossing counts; a later one leaves the register in charge
          if (timing_s && cnt < OPEN_CYC) begin
            next_open = 1'b1;
          end
          if (therm_s) begin
            next_fault = 1'b1;
          end
          if (good_s) begin
            next_state = ST_RUN;
            next_cnt   = 32'h0;
            next_fault = therm_s;
          end else if (start_exp) begin
            next_cnt   = 32'h0;
            next_fault = 1'b1;
            if (mode == MODE_CONT) begin
              next_state = ST_RUN;
            end else begin
              next_state = fail_state;
            end
          end
        end
        ST_RUN: begin
          next_blank = oc_s ? blank_cnt + 32'h1 : 32'h0;
          if (good_s) begin
            next_fault = 1'b0;
          end
          if (therm_s) begin
            next_fault = 1'b1;
            if (mode != MODE_CONT) begin
              next_state = fail_state;
              next_blank = 32'h0;
              next_cnt   = 32'h0;
            end
          end else if (blank_hit) begin
            next_blank = 32'h0;
            next_fault = 1'b1;
            if (mode != MODE_CONT) begin
              next_state = fail_state;
              next_cnt   = 32'h0;
            end
          end
        end
        ST_RETRY: begin
          // Retry delay counts only while the thermal trip is clear; a trip holds the count
          if (!therm_s) begin
            next_cnt = cnt + 32'h1;
            if (retry_exp) begin
              next_state = ST_START;
              next_cnt   = 32'h0;
              next_open  = 1'b0;
            end
          end
        end
        ST_LATCH: begin
          next_state = ST_LATCH;
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end
  wire logic next_sw = en_s && !therm_s && mode_ok &&
                       (next_state == ST_START || next_state == ST_RUN);
  wire logic next_reg = next_sw && oc_s;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state              <= ST_START;
      cnt                <= 32'h0;
      blank_cnt          <= 32'h0;
      fault              <= 1'b0;
      open_det           <= 1'b0;
      output_switch_o    <= 1'b0;
      regulate_o         <= 1'b0;
      forward_fault_n_o  <= 1'b1;
      forward_fault_oe_o <= 1'b0;
    end else if (ce_i && mode_ok) begin
      state              <= next_state;
      cnt                <= next_cnt;
      blank_cnt          <= next_blank;
      fault              <= next_fault;
      open_det           <= next_open;
      output_switch_o    <= next_sw;
      regulate_o         <= next_reg;
      forward_fault_n_o  <= !next_fault;
      forward_fault_oe_o <= next_fault;
    end
  end
  // ****************************************
  // APB slave
  // ****************************************
  // Zero-wait answer: pready rises in the first access cycle
  wire logic setup    = psel_i && !penable_i;
  wire logic wr_go    = psel_i && penable_i && pwrite_i && pready_o;
  wire logic hit_strt = (paddr_i == `REG_START_OFS);
  wire logic hit_blnk = (paddr_i == `REG_BLANK_OFS);
  wire logic hit_stat = (paddr_i == `REG_STATUS_OFS);
  // Unmapped offsets answer with an error and read as zero
  wire logic [31:0] status = {23'h0, regulate_o, open_det, output_switch_o,
                              fault, mode, state};
  wire logic [31:0] rd_mux = hit_strt ? start_reg :
                             hit_blnk ? blank_reg :
                             hit_stat ? status : 32'h0;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      start_reg <= `START_RST;
      blank_reg <= `BLANK_RST;
    end else if (ce_i) begin
      pready_o  <= setup;
      pslverr_o <= setup && !(hit_strt || hit_blnk || hit_stat);
      prdata_o  <= (setup && !pwrite_i) ? rd_mux : 32'h0;
      if (wr_go && hit_strt) begin
        start_reg <= pwdata_i;
      end
      if (wr_go && hit_blnk) begin
        blank_reg <= pwdata_i;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  // Checks wait for the strap capture, since the sequencer is frozen before it
  default disable iff (sys_rst_i || !ce_i || !mode_ok);
  AST_THERM_OFF: assert property (therm_s |=> !output_switch_o)
    else $error("switch on during thermal trip");
  AST_REGULATE: assert property (next_sw && oc_s |=> regulate_o && output_switch_o)
    else $error("overcurrent without regulation");
  AST_REG_SW: assert property (regulate_o |-> output_switch_o)
    else $error("regulation with switch off");
  AST_GOOD_START: assert property (state == ST_START && good_s && en_s
    |=> state == ST_RUN && cnt == 32'h0)
    else $error("output good did not end startup");
  AST_CONT_EXP: assert property (state == ST_START && mode == MODE_CONT && start_exp
    && !good_s && en_s && !therm_s |=> fault && output_switch_o && !forward_fault_n_o)
    else $error("continuous startup expiry wrong");
  AST_AUTO_START: assert property (state == ST_START && mode == MODE_AUTO && start_exp
    && !good_s && en_s |=> state == ST_RETRY && fault && !output_switch_o)
    else $error("autoretry startup expiry wrong");
  AST_LATCH_START: assert property (state == ST_START && mode == MODE_LATCH && start_exp
    && !good_s && en_s |=> state == ST_LATCH && fault && !output_switch_o)
    else $error("latchoff startup expiry wrong");
  AST_START_THERM: assert property (state == ST_START && en_s && therm_s && !good_s
    && !start_exp |=> state == ST_START && fault && !output_switch_o)
    else $error("thermal during startup handled wrong");
  AST_BLANK_CLR: assert property (state == ST_RUN && en_s && !oc_s |=> blank_cnt == 32'h0)
    else $error("blanking timer not cleared");
  AST_CONT_OC: assert property (state == ST_RUN && mode == MODE_CONT && blank_hit
    && !therm_s && en_s |=> fault && output_switch_o && blank_cnt == 32'h0)
    else $error("continuous overcurrent response wrong");
  AST_RELEASE: assert property (state == ST_RUN && en_s && good_s && !therm_s && !blank_hit
    |=> !fault)
    else $error("flag not released on output good");
  AST_RETRY_OFF: assert property (state == ST_RETRY && $past(state) == ST_RETRY
    |-> !output_switch_o)
    else $error("switch on during retry delay");
  AST_AUTO_FAIL: assert property (state == ST_RUN && mode == MODE_AUTO && en_s
    && (therm_s || blank_hit) |=> state == ST_RETRY && fault ##1 !output_switch_o)
    else $error("autoretry fault response wrong");
  AST_LATCH_FAIL: assert property (state == ST_RUN && mode == MODE_LATCH && en_s
    && (therm_s || blank_hit) |=> state == ST_LATCH ##1 !output_switch_o)
    else $error("latchoff fault response wrong");
  AST_LATCH_HOLD: assert property (state == ST_LATCH && en_s
    |=> state == ST_LATCH && fault)
    else $error("latch released without enable toggle");
  AST_OFF_CLEAR: assert property (state == ST_OFF |-> !output_switch_o && forward_fault_n_o)
    else $error("disabled state left switch or flag active");
  AST_OPEN: assert property (state == ST_START && en_s && timing_s && cnt < OPEN_CYC
    |=> open_det)
    else $error("open timing input not detected");
  COV_RUN: cover property (state == ST_START ##1 state == ST_RUN);
  COV_RETRY: cover property (state == ST_RETRY ##1 state == ST_START);
  COV_LATCH: cover property (state == ST_LATCH ##1 state == ST_OFF);
  COV_OPEN: cover property (state == ST_START && open_det ##1 state == ST_RETRY);
  COV_START_THERM: cover property (state == ST_START && therm_s);
endmodule : fault_ctrl

// ### fault_params.svh
/*
 Constants of the current-limit fault sequencer: offsets, fields, resets, timing.
 Assumes a 25 MHz system clock and inclusion by bare name.
*/
`ifndef FAULT_PARAMS_SVH
`define FAULT_PARAMS_SVH
// ****************************************
// Register map
// ****************************************
`define REG_START_OFS   8'h00
`define REG_BLANK_OFS   8'h04
`define REG_STATUS_OFS  8'h08
`define START_RST       32'h0016_E360
`define BLANK_RST       32'h0000_61A8
// ****************************************
// Status fields
// ****************************************
`define ST_STATE_LSB    0
`define ST_MODE_LSB     3
`define ST_FAULT_BIT    5
`define ST_SWITCH_BIT   6
`define ST_OPEN_BIT     7
`define ST_REG_BIT      8
// ****************************************
// Input bit positions
// ****************************************
`define IN_STRAP_LSB    0
`define IN_OC_BIT       2
`define IN_GOOD_BIT     3
`define IN_THERM_BIT    4
`define IN_EN_BIT       5
`define IN_TIMING_BIT   6
`define IN_WIDTH        7
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   40
`define OPEN_DETECT_US  100
`define OPEN_DETECT_CYC (`OPEN_DETECT_US * 1000 / `CLK_PERIOD_NS)
`define DEF_START_MS    15
`define DEF_START_CYC   (`DEF_START_MS * 1000000 / `CLK_PERIOD_NS)
`define RETRY_MS        1000
`define RETRY_CYC       (`RETRY_MS * 1000000 / `CLK_PERIOD_NS)
`endif

// ### fault_pkg.sv
/*
 Types of the fault sequencer: sequence states and limit modes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fault_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_START = 3'h1,
    ST_RUN   = 3'h3,
    ST_RETRY = 3'h2,
    ST_LATCH = 3'h6
  } seq_state_t;
  typedef enum logic [1:0] {
    MODE_CONT  = 2'h0,
    MODE_LATCH = 2'h1,
    MODE_AUTO  = 2'h2
  } limit_mode_t;
endpackage : fault_pkg

// ### cond_if.sv
/*
 Carrier between the sequencer and its input synchroniser.
 Assumes both sides share one clock.
*/
`timescale 1ns/1ps
interface cond_if #(parameter int W = 7);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sampler (input raw, output sync);
  modport user    (output raw, input sync);
endinterface : cond_if

// ### cond_sync.sv
/*
 Two-stage synchroniser for each condition input.
 Assumes a clock enable that freezes both stages.
*/
`timescale 1ns/1ps
module cond_sync #(
  parameter int W = 7
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  cond_if.sampler   c
);
  logic [W-1:0] meta;
  logic [W-1:0] sync_q;
  // ****************************************
  // One synchroniser per input bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          meta[g]   <= 1'b0;
          sync_q[g] <= 1'b0;
        end else if (ce_i) begin
          meta[g]   <= c.raw[g];
          sync_q[g] <= meta[g];
        end
      end
    end
  endgenerate
  assign c.sync = sync_q;
endmodule : cond_sync

// ### load_model.sv
/*
 Load model: output capacitor that charges under the current limit, or a hard short.
 Assumes the sequencer's clock and a bench that commands the short.
*/
`timescale 1ns/1ps
module load_model #(
  parameter int CHARGE_CYC = 10
) (
  input  wire logic clk_i,
  input  wire logic switch_i,
  input  wire logic short_i,
  output logic      overcurrent_o,
  output logic      output_good_o
);
  int unsigned level;
  // Drops at once when the switch opens: worst case for a restart
  always_ff @(posedge clk_i) begin
    if (!switch_i) level <= 0;
    else if (level < CHARGE_CYC) level <= level + 1;
  end
  assign overcurrent_o = switch_i && (short_i || level < CHARGE_CYC);
  assign output_good_o = switch_i && !short_i && level >= CHARGE_CYC;
endmodule : load_model

// ### tb_top.sv
/*
 Self-checking bench of the fault sequencer: APB tasks and mode scenarios.
 Assumes short retry and default start parameters and the load model.
*/
`timescale 1ns/1ps
`include "fault_params.svh"
module tb_top;
  import fault_pkg::*;
  logic        clk = 0, rst = 1, en = 0, therm = 0, short = 0, timing = 0;
  logic        psel = 0, penable = 0, pwrite = 0, oc, good;
  logic [1:0]  strap = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, sw, reg_on, fault_n, fault_oe, e;
  int          miscompares = 0, checks_done = 0, n;

  always #20 clk = ~clk;

  fault_ctrl #(.DEF_START_CYC(50), .RETRY_CYC(40)) u_fault_ctrl (
    .clk_i(clk), .sys_rst_i(rst), .ce_i(1'h1), .limit_mode_strap_i(strap),
    .overcurrent_i(oc), .output_good_i(good), .thermal_trip_i(therm), .enable_i(en),
    .startup_timing_input_i(timing), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .output_switch_o(sw), .regulate_o(reg_on),
    .forward_fault_n_o(fault_n), .forward_fault_oe_o(fault_oe));

  load_model #(.CHARGE_CYC(10)) u_load_model (
    .clk_i(clk), .switch_i(sw), .short_i(short), .overcurrent_o(oc), .output_good_o(good));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Called at a rising edge; lets one edge pass after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) begin
      check("apb timeout", 32'h1, 32'h0);
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic wait_out(input int sel, input logic v);
    n = 0;
    while ((sel == 0 ? sw : fault_n) !== v) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        check("wait timeout", 32'h1, 32'h0);
        print_verdict();
      end
    end
  endtask : wait_out

  task automatic boot(input logic [1:0] m);
    strap <= m; en <= 1'h0; rst <= 1'h1; short <= 1'h0; therm <= 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h1, `REG_START_OFS, 32'h0000_001E);
    apb(1'h1, `REG_BLANK_OFS, 32'h0000_000A);
    apb(1'h0, `REG_STATUS_OFS, 32'h0);
    check("mode", {30'h0, r[4:3]}, {30'h0, (m == 2'h3) ? 2'h2 : m});
    en <= 1'h1;
  endtask : boot

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    check("switch in reset", sw, 32'h0);
    check("flag in reset", fault_n, 32'h1);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, `REG_START_OFS, 32'h0);
    check("start reset", r, `START_RST);
    apb(1'h0, `REG_BLANK_OFS, 32'h0);
    check("blank reset", r, `BLANK_RST);
    apb(1'h0, 8'h0C, 32'h0);
    check("unmapped err", e, 32'h1);
    check("unmapped data", r, 32'h0);
    // Continuous: shorted start, thermal, then recovery
    boot(2'h0);
    short <= 1'h1;
    wait_out(1, 1'h0);
    check("cont switch", sw, 32'h1);
    check("regulate", reg_on, 32'h1);
    check("flag pin drive", fault_oe, 32'h1);
    therm <= 1'h1;
    repeat (4) @(posedge clk);
    check("thermal off", sw, 32'h0);
    therm <= 1'h0;
    wait_out(0, 1'h1);
    check("flag held", fault_n, 32'h0);
    short <= 1'h0;
    wait_out(1, 1'h1);
    apb(1'h0, `REG_STATUS_OFS, 32'h0);
    check("cont state", {29'h0, r[2:0]}, {29'h0, ST_RUN});
    // Autoretry: retry loop, recovery, then blanking in run
    boot(2'h2);
    short <= 1'h1;
    wait_out(1, 1'h0);
    check("auto off", sw, 32'h0);
    check("start length", 32'(n >= 30 && n <= 40), 32'h1);
    wait_out(0, 1'h1);
    check("retry length", 32'(n >= 38 && n <= 46), 32'h1);
    check("flag in retry", fault_n, 32'h0);
    short <= 1'h0;
    wait_out(1, 1'h1);
    check("auto on", sw, 32'h1);
    short <= 1'h1;
    repeat (5) @(posedge clk);
    short <= 1'h0;
    repeat (20) @(posedge clk);
    check("short pulse", fault_n, 32'h1);
    short <= 1'h1;
    wait_out(0, 1'h0);
    check("blank flag", fault_n, 32'h0);
    check("blank length", 32'(n >= 10 && n <= 16), 32'h1);
    // Latchoff: latched start fault, enable toggle, thermal latch
    boot(2'h1);
    short <= 1'h1;
    wait_out(1, 1'h0);
    check("latch off", sw, 32'h0);
    repeat (100) @(posedge clk);
    check("latch held", sw, 32'h0);
    apb(1'h0, `REG_STATUS_OFS, 32'h0);
    check("latch state", {29'h0, r[2:0]}, {29'h0, ST_LATCH});
    short <= 1'h0;
    en <= 1'h0;
    repeat (2) @(posedge clk);
    en <= 1'h1;
    wait_out(0, 1'h1);
    wait_out(1, 1'h1);
    check("relaunch", sw, 32'h1);
    repeat (40) @(posedge clk);
    therm <= 1'h1;
    wait_out(0, 1'h0);
    check("thermal flag", fault_n, 32'h0);
    therm <= 1'h0;
    repeat (100) @(posedge clk);
    check("thermal latch", sw, 32'h0);
    // Open timing input, other open strap code, thermal during startup
    timing <= 1'h1;
    boot(2'h3);
    short <= 1'h1;
    repeat (10) @(posedge clk);
    therm <= 1'h1;
    repeat (4) @(posedge clk);
    check("start thermal off", sw, 32'h0);
    apb(1'h0, `REG_STATUS_OFS, 32'h0);
    check("start thermal state", {29'h0, r[2:0]}, {29'h0, ST_START});
    check("start thermal flag", {31'h0, r[5]}, 32'h1);
    therm <= 1'h0;
    wait_out(0, 1'h1);
    wait_out(0, 1'h0);
    check("default length", 32'(n >= 30 && n <= 36), 32'h1);
    apb(1'h0, `REG_STATUS_OFS, 32'h0);
    check("open detect", {31'h0, r[7]}, 32'h1);
    check("open retry", {29'h0, r[2:0]}, {29'h0, ST_RETRY});
    timing <= 1'h0;
    print_verdict();
  end
endmodule : tb_top
